// ### common/uart_alias_pkg.sv
// shared constants for the shadow receive/transmit alias block
package uart_alias_pkg;
  localparam int          ADDR_W       = 32;
  localparam int          DATA_W       = 32;
  localparam int          CHAR_W       = 8;
  localparam int          ALIAS_COUNT  = 16;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          NUM_EVENTS   = 4;

  // alias bank: sixteen word locations, eighth and ninth as printed
  localparam logic [31:0] ALIAS8_ADDR  = 32'h5000_1050;
  localparam logic [31:0] ALIAS9_ADDR  = 32'h5000_1054;
  localparam logic [31:0] ALIAS_BASE   = ALIAS8_ADDR - 32'h0000_0020;
  localparam logic [31:0] ALIAS_SPAN   = 32'h0000_0040;
  localparam logic [15:0] ALIAS_RESET  = 16'h0000;

  // control and status words outside the alias bank
  localparam logic [31:0] CTRL_ADDR    = 32'h5000_1100;
  localparam logic [31:0] LSTAT_ADDR   = 32'h5000_1104;
  localparam logic [31:0] ISTAT_ADDR   = 32'h5000_1108;
  localparam logic [31:0] IMASK_ADDR   = 32'h5000_110c;

  localparam int          CTRL_FIFO_EN = 0;
  localparam int          CTRL_IR_MODE = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h0;

  localparam int          LS_DATA_RDY  = 0;
  localparam int          LS_OVERRUN   = 1;
  localparam int          LS_TX_EMPTY  = 5;

  localparam int          EV_RX_CHAR   = 0;
  localparam int          EV_OVERRUN   = 1;
  localparam int          EV_TX_EMPTY  = 2;
  localparam int          EV_TX_DROP   = 3;
endpackage : uart_alias_pkg

// ### hdl/byte_fifo.sv
// character queue that can also act as a single overwritable holding slot
module byte_fifo #(
  parameter int  DEPTH = 16,
  parameter int  WIDTH = 8,
  localparam int PW    = $clog2(DEPTH),
  localparam int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic             flush,
  input  wire logic             single,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] head,
  output logic      [CW-1:0]    count,
  output logic                  full,
  output logic                  empty,
  output logic                  dropped,
  output logic                  overwrote
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd_ptr;
    logic [PW-1:0]               wr_ptr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        do_pop;
  logic        do_push;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : bump

  always_comb begin
    next_st   = st;
    empty     = (st.count == '0);
    full      = single ? !empty : (st.count == CW'(DEPTH));
    do_pop    = pop && !empty;
    do_push   = push && (!full || do_pop);
    // single slot keeps only the newest character
    overwrote = push && single && full && !do_pop;
    dropped   = push && !do_push && !overwrote;
    if (flush) begin
      next_st.rd_ptr = '0;
      next_st.wr_ptr = '0;
      next_st.count  = '0;
    end else begin
      if (overwrote) begin
        next_st.mem[st.rd_ptr] = push_data;
      end
      if (do_push) begin
        next_st.mem[st.wr_ptr] = push_data;
        next_st.wr_ptr         = bump(st.wr_ptr);
      end
      if (do_pop) begin
        next_st.rd_ptr = bump(st.rd_ptr);
      end
      next_st.count = st.count + CW'(do_push) - CW'(do_pop);
    end
    head  = st.mem[st.rd_ptr];
    count = st.count;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else if (enable) begin
      st <= next_st;
    end
  end
endmodule : byte_fifo

// ### hdl/event_irq.sv
// sticky event flags, write-one-to-clear, masked onto one interrupt level
module event_irq #(
  parameter int N = 4
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic         enable,
  input  wire logic [N-1:0] events,
  input  wire logic         clear_wr,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } irq_state_t;

  irq_state_t st;
  irq_state_t next_st;

  always_comb begin
    next_st = st;
    // a new event beats a clear in the same cycle
    next_st.status = (st.status & ~(clear_wr ? wdata : '0)) | events;
    if (mask_wr) begin
      next_st.mask = wdata;
    end
    status = st.status;
    mask   = st.mask;
    irq    = |(st.status & st.mask);
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else if (enable) begin
      st <= next_st;
    end
  end
endmodule : event_irq

// ### hdl/uart_shadow_alias.sv
// shadow receive/transmit alias bank with its queues, flags and interrupt
//
// How it works
// - sixteen word locations all reach the same receive/transmit path
// - alias read returns byte from serial, or infrared input in ir mode
// - alias read data is valid only while the data ready flag is set
// - without fifos a new character overwrites unread one, flags overrun
// - with fifos an alias read returns the receive queue head
// - full receive queue keeps contents, drops new character, flags overrun
// - alias write queues byte for serial output, or infrared output
// - without fifos a write clears empty flag; later writes overwrite
// - with fifos, writes are accepted up to the queue depth
// - writes into a full transmit queue are discarded, queue unchanged
//
// Our own choice: the plain strobed port.
module uart_shadow_alias #(
  parameter int DEPTH = uart_alias_pkg::FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clock_enable,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic [7:0]  rx_serial_char,
  input  wire logic        rx_serial_strobe,
  input  wire logic [7:0]  rx_ir_char,
  input  wire logic        rx_ir_strobe,
  output logic      [7:0]  tx_char,
  output logic             tx_serial_valid,
  output logic             tx_ir_valid,
  input  wire logic        tx_char_taken,
  output logic             irq
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int NE = uart_alias_pkg::NUM_EVENTS;

  typedef struct packed {
    logic        fifo_enable;
    logic        ir_mode;
    logic        overrun;
    logic        tx_holding_empty_flag_prev;
    logic [31:0] rdata;
    logic [7:0]  tx_char;
    logic        tx_busy;
    logic        tx_to_ir;
  } alias_state_t;

  alias_state_t st;
  alias_state_t next_st;

  logic          alias_hit;
  logic          alias_read;
  logic          tx_push;
  logic          tx_pop;
  logic          rx_strobe;
  logic [7:0]    rx_char;
  logic          flush;
  logic          ctrl_wr;
  logic [7:0]    rx_head;
  logic [CW-1:0] rx_count;
  logic          rx_full;
  logic          rx_empty;
  logic          rx_dropped;
  logic          rx_overwrote;
  logic [7:0]    tx_head;
  logic [CW-1:0] tx_count;
  logic          tx_full;
  logic          tx_empty;
  logic          tx_dropped;
  logic [NE-1:0] events;
  logic [NE-1:0] int_status;
  logic [NE-1:0] int_mask;
  logic [31:0]   line_status;

  // word-aligned hit anywhere in the alias bank
  function automatic logic is_alias(input logic [31:0] a);
    return (a >= uart_alias_pkg::ALIAS_BASE) &&
           (a < uart_alias_pkg::ALIAS_BASE + uart_alias_pkg::ALIAS_SPAN) &&
           (a[1:0] == 2'h0);
  endfunction : is_alias

  function automatic logic hit(input logic [31:0] a, input logic [31:0] b);
    return a == b;
  endfunction : hit

  always_comb begin
    alias_hit  = is_alias(reg_addr);
    alias_read = reg_read && alias_hit;
    tx_push    = reg_write && alias_hit;
    ctrl_wr    = reg_write && hit(reg_addr, uart_alias_pkg::CTRL_ADDR);
    rx_strobe  = st.ir_mode ? rx_ir_strobe : rx_serial_strobe;
    rx_char    = st.ir_mode ? rx_ir_char : rx_serial_char;
    // changing the queue mode empties both queues
    flush      = ctrl_wr &&
                 (reg_wdata[uart_alias_pkg::CTRL_FIFO_EN] != st.fifo_enable);
    // reload the shifter as soon as the previous character is taken
    tx_pop     = (!st.tx_busy || tx_char_taken) && !tx_empty && !flush;
  end

  byte_fifo #(
    .DEPTH     (DEPTH),
    .WIDTH     (uart_alias_pkg::CHAR_W)
  ) rx_queue (
    .clock     (clock),
    .reset_n   (reset_n),
    .enable    (clock_enable),
    .flush     (flush),
    .single    (!st.fifo_enable),
    .push      (rx_strobe),
    .pop       (alias_read),
    .push_data (rx_char),
    .head      (rx_head),
    .count     (rx_count),
    .full      (rx_full),
    .empty     (rx_empty),
    .dropped   (rx_dropped),
    .overwrote (rx_overwrote)
  );

  byte_fifo #(
    .DEPTH     (DEPTH),
    .WIDTH     (uart_alias_pkg::CHAR_W)
  ) tx_queue (
    .clock     (clock),
    .reset_n   (reset_n),
    .enable    (clock_enable),
    .flush     (flush),
    .single    (!st.fifo_enable),
    .push      (tx_push),
    .pop       (tx_pop),
    .push_data (reg_wdata[7:0]),
    .head      (tx_head),
    .count     (tx_count),
    .full      (tx_full),
    .empty     (tx_empty),
    .dropped   (tx_dropped),
    .overwrote ()
  );

  always_comb begin
    line_status = '0;
    line_status[uart_alias_pkg::LS_DATA_RDY] = !rx_empty;
    line_status[uart_alias_pkg::LS_OVERRUN]  = st.overrun;
    line_status[uart_alias_pkg::LS_TX_EMPTY] = tx_empty;
    events = '0;
    events[uart_alias_pkg::EV_RX_CHAR]  = rx_strobe;
    events[uart_alias_pkg::EV_OVERRUN]  = rx_dropped || rx_overwrote;
    events[uart_alias_pkg::EV_TX_EMPTY] = tx_empty && !st.tx_holding_empty_flag_prev;
    events[uart_alias_pkg::EV_TX_DROP]  = tx_dropped;
  end

  event_irq #(
    .N        (NE)
  ) irq_unit (
    .clock    (clock),
    .reset_n  (reset_n),
    .enable   (clock_enable),
    .events   (events),
    .clear_wr (reg_write && hit(reg_addr, uart_alias_pkg::ISTAT_ADDR)),
    .mask_wr  (reg_write && hit(reg_addr, uart_alias_pkg::IMASK_ADDR)),
    .wdata    (reg_wdata[NE-1:0]),
    .status   (int_status),
    .mask     (int_mask),
    .irq      (irq)
  );

  always_comb begin
    next_st           = st;
    next_st.tx_holding_empty_flag_prev = tx_empty;
    next_st.rdata     = '0;
    if (ctrl_wr) begin
      next_st.fifo_enable = reg_wdata[uart_alias_pkg::CTRL_FIFO_EN];
      next_st.ir_mode     = reg_wdata[uart_alias_pkg::CTRL_IR_MODE];
    end
    // overrun is sticky until line status is read; a new one wins
    if (reg_read && hit(reg_addr, uart_alias_pkg::LSTAT_ADDR)) begin
      next_st.overrun = 1'b0;
    end
    if (rx_dropped || rx_overwrote) begin
      next_st.overrun = 1'b1;
    end
    if (reg_read) begin
      if (alias_hit) begin
        next_st.rdata = {24'h00_0000, rx_head};
      end else begin
        unique case (reg_addr)
          uart_alias_pkg::CTRL_ADDR:
            next_st.rdata = {30'h0000_0000, st.ir_mode, st.fifo_enable};
          uart_alias_pkg::LSTAT_ADDR:
            next_st.rdata = line_status;
          uart_alias_pkg::ISTAT_ADDR:
            next_st.rdata = {28'h000_0000, int_status};
          uart_alias_pkg::IMASK_ADDR:
            next_st.rdata = {28'h000_0000, int_mask};
          default:
            next_st.rdata = '0;
        endcase
      end
    end
    if (tx_char_taken || flush) begin
      next_st.tx_busy = 1'b0;
    end
    if (tx_pop) begin
      next_st.tx_char  = tx_head;
      next_st.tx_busy  = 1'b1;
      next_st.tx_to_ir = st.ir_mode;
    end
    reg_rdata       = st.rdata;
    tx_char         = st.tx_char;
    tx_serial_valid = st.tx_busy && !st.tx_to_ir;
    tx_ir_valid     = st.tx_busy && st.tx_to_ir;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st             <= '0;
      st.fifo_enable <=
        uart_alias_pkg::CTRL_RESET[uart_alias_pkg::CTRL_FIFO_EN];
      st.ir_mode     <=
        uart_alias_pkg::CTRL_RESET[uart_alias_pkg::CTRL_IR_MODE];
      st.tx_holding_empty_flag_prev   <= 1'b1;
    end else if (clock_enable) begin
      st <= next_st;
    end
  end

  // ---- checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence s_alias_read;
    clock_enable && alias_read;
  endsequence

  sequence s_idle_write;
    clock_enable && tx_push && tx_empty && !st.tx_busy && !flush;
  endsequence

  property p_read_head;
    logic [7:0] h;
    (s_alias_read, h = rx_head) |=> reg_rdata[7:0] == h;
  endproperty

  a_upper_bits_zero: assert property (
    s_alias_read |=> reg_rdata[31:8] == 24'h00_0000)
    else $error("alias read shows nonzero upper bits");

  a_read_gives_head: assert property (p_read_head)
    else $error("alias read did not return queue head");

  a_read_pops_one: assert property (
    clock_enable && alias_read && !rx_empty && !rx_strobe && !flush
    |=> rx_count == $past(rx_count) - CW'(1))
    else $error("alias read did not remove one character");

  a_ready_flag_shown: assert property (
    clock_enable && reg_read &&
    hit(reg_addr, uart_alias_pkg::LSTAT_ADDR)
    |=> reg_rdata[uart_alias_pkg::LS_DATA_RDY] == $past(!rx_empty))
    else $error("data ready flag does not match queue");

  a_single_overwrite: assert property (
    clock_enable && !st.fifo_enable && rx_strobe && !rx_empty &&
    !alias_read && !flush
    |=> st.overrun && rx_head == $past(rx_char) && rx_count == CW'(1))
    else $error("unread character not overwritten with overrun");

  a_full_rx_keeps: assert property (
    clock_enable && st.fifo_enable && rx_full && rx_strobe &&
    !alias_read && !flush
    |=> st.overrun && rx_count == $past(rx_count) &&
        rx_head == $past(rx_head))
    else $error("full receive queue changed on arrival");

  a_input_select: assert property (
    clock_enable && !st.ir_mode && rx_ir_strobe && !rx_serial_strobe &&
    rx_empty && !ctrl_wr
    |=> rx_empty)
    else $error("infrared input taken in serial mode");

  a_tx_route: assert property (
    s_idle_write ##1 clock_enable
    |=> tx_char == $past(reg_wdata[7:0], 2) &&
        tx_ir_valid == $past(st.ir_mode) &&
        (tx_serial_valid || tx_ir_valid))
    else $error("written byte not presented on the chosen output");

  a_tx_holding_empty_flag_clears: assert property (
    clock_enable && !st.fifo_enable && tx_empty && tx_push &&
    st.tx_busy && !tx_char_taken && !flush
    |=> !tx_empty)
    else $error("transmit empty flag not cleared by write");

  a_hold_overwrite: assert property (
    clock_enable && !st.fifo_enable && !tx_empty && tx_push &&
    st.tx_busy && !tx_char_taken && !flush
    |=> tx_head == $past(reg_wdata[7:0]) && tx_count == CW'(1))
    else $error("held transmit byte not overwritten");

  a_depth_accepts: assert property (
    clock_enable && st.fifo_enable && tx_push && !tx_full && !flush
    |=> tx_count == $past(tx_count) + CW'(1) - CW'($past(tx_pop)))
    else $error("write below depth not accepted");

  a_full_tx_drops: assert property (
    clock_enable && st.fifo_enable && tx_push && tx_full && !tx_pop &&
    !flush
    |=> tx_count == $past(tx_count) &&
        int_status[uart_alias_pkg::EV_TX_DROP])
    else $error("write into full transmit queue not discarded");
endmodule : uart_shadow_alias

// ### verif/serial_peer.sv
// far-side serial peer: sends characters in and takes characters out
module serial_peer (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       send,
  input  wire logic [7:0] send_char,
  input  wire logic       ir,
  input  wire logic       stall,
  output logic      [7:0] rx_serial_char,
  output logic            rx_serial_strobe,
  output logic      [7:0] rx_ir_char,
  output logic            rx_ir_strobe,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_serial_valid,
  input  wire logic       tx_ir_valid,
  output logic            tx_char_taken
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_char;
  logic [8:0] log_mem [0:31];
  int         got_cnt;
  logic       offered;
  assign offered          = tx_serial_valid | tx_ir_valid;
  assign rx_serial_strobe = send & ~ir;
  assign rx_ir_strobe     = send & ir;
  // idle data lines show the inverse of the last character, never stale data
  assign rx_serial_char   = rx_serial_strobe ? send_char : ~last_char;
  assign rx_ir_char       = rx_ir_strobe ? send_char : ~last_char;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      last_char     <= 8'h00;
      tx_char_taken <= 1'b0;
      got_cnt       <= 0;
    end else begin
      if (send)
        last_char <= send_char;
      // one-cycle take pulse, held off while stalled
      tx_char_taken <= offered & ~stall & ~tx_char_taken;
      if (tx_char_taken & offered) begin
        log_mem[got_cnt[4:0]] <= {tx_ir_valid, tx_char};
        got_cnt <= got_cnt + 1;
      end
    end
  end
endmodule : serial_peer

// ### verif/tb_top.sv
// self-checking testbench for the shadow receive/transmit alias bank
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          D  = 4;
  localparam logic [31:0] CT = uart_alias_pkg::CTRL_ADDR;
  localparam logic [31:0] LS = uart_alias_pkg::LSTAT_ADDR;
  localparam logic [31:0] IS = uart_alias_pkg::ISTAT_ADDR;
  localparam logic [31:0] IM = uart_alias_pkg::IMASK_ADDR;
  typedef struct packed {
    logic [3:0] idx;
    logic       ir;
    logic [7:0] ch;
  } row_t;
  row_t        rows [4] = '{'{4'h0, 1'b0, 8'ha5}, '{4'h8, 1'b1, 8'h3c},
                            '{4'h9, 1'b0, 8'hff}, '{4'hf, 1'b1, 8'h00}};
  logic        clock;
  logic        reset_n;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_write;
  logic        reg_read;
  logic        send;
  logic [7:0]  send_char;
  logic        ir;
  logic        stall;
  logic [7:0]  rxs_char;
  logic        rxs_strobe;
  logic [7:0]  rxi_char;
  logic        rxi_strobe;
  logic [7:0]  tx_char;
  logic        txs_valid;
  logic        txi_valid;
  logic        taken;
  logic        irq;
  logic        ce;
  logic [31:0] d;
  int          error_cnt;
  int          n_compared;
  int          n0;

  always #12.5 clock = ~clock;

  uart_shadow_alias #(.DEPTH(D)) dut_u (
    .clock(clock), .reset_n(reset_n), .clock_enable(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .rx_serial_char(rxs_char), .rx_serial_strobe(rxs_strobe),
    .rx_ir_char(rxi_char), .rx_ir_strobe(rxi_strobe), .tx_char(tx_char),
    .tx_serial_valid(txs_valid), .tx_ir_valid(txi_valid),
    .tx_char_taken(taken), .irq(irq));

  serial_peer peer_u (
    .clock(clock), .reset_n(reset_n), .send(send), .send_char(send_char),
    .ir(ir), .stall(stall), .rx_serial_char(rxs_char),
    .rx_serial_strobe(rxs_strobe), .rx_ir_char(rxi_char),
    .rx_ir_strobe(rxi_strobe), .tx_char(tx_char),
    .tx_serial_valid(txs_valid), .tx_ir_valid(txi_valid),
    .tx_char_taken(taken));

  function automatic logic [31:0] al(input logic [3:0] i);
    return uart_alias_pkg::ALIAS_BASE + {26'h0, i, 2'b00};
  endfunction : al

  task automatic complete_run();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [31:0] a, input logic [31:0] w);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 r = reg_rdata;
  endtask : rd

  task automatic rx(input logic [7:0] c);
    @(posedge clock);
    send      <= 1'b1;
    send_char <= c;
    @(posedge clock);
    send      <= 1'b0;
  endtask : rx

  task automatic wait_tx(input int n);
    for (int i = 0; i < 200 && peer_u.got_cnt < n; i++)
      @(posedge clock);
    chk("tx count", 32'(n), 32'(peer_u.got_cnt));
    if (peer_u.got_cnt != n)
      complete_run();
  endtask : wait_tx

  task automatic irq_is(input logic v);
    @(posedge clock);
    #1 chk("irq", {31'h0, v}, {31'h0, irq});
  endtask : irq_is

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    send = 1'b0;
    send_char = 8'h00;
    ir = 1'b0;
    stall = 1'b0;
    ce = 1'b1;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    rd(al(4'h8), d);
    chk("alias reset", 32'h0, d);
    rd(LS, d);
    chk("line status reset", 32'h20, d & 32'h23);
    chk("irq reset", 32'h0, {31'h0, irq});
    foreach (rows[i]) begin
      wr(CT, {30'h0, rows[i].ir, 1'b0});
      ir <= rows[i].ir;
      rx(rows[i].ch);
      rd(LS, d);
      chk("data ready", 32'h1, d & 32'h1);
      rd(al(rows[i].idx), d);
      chk("alias read", {24'h0, rows[i].ch}, d);
      rd(LS, d);
      chk("ready after read", 32'h20, d & 32'h21);
      wr(al(rows[i].idx), 32'hffff_ff00 | {24'h0, rows[i].ch});
      wait_tx(i + 1);
      chk("tx char", {23'h0, rows[i].ir, rows[i].ch},
          {23'h0, peer_u.log_mem[i]});
    end
    wr(CT, 32'h0);
    ir <= 1'b0;
    rx(8'h11);
    rx(8'h22);
    rd(LS, d);
    chk("overrun single", 32'h23, d & 32'h23);
    rd(al(4'h3), d);
    chk("overwritten char", 32'h22, d);
    // shifter holds the first byte, holding slot then takes the rest
    stall <= 1'b1;
    n0 = peer_u.got_cnt;
    wr(al(4'h0), 32'h31);
    repeat (3) @(posedge clock);
    rd(LS, d);
    chk("holding empty", 32'h20, d & 32'h20);
    wr(al(4'h1), 32'h32);
    rd(LS, d);
    chk("holding full", 32'h0, d & 32'h20);
    wr(al(4'h2), 32'h33);
    stall <= 1'b0;
    wait_tx(n0 + 2);
    chk("tx first", 32'h31, {23'h0, peer_u.log_mem[n0]});
    chk("tx overwrite", 32'h33, {23'h0, peer_u.log_mem[n0 + 1]});
    wr(CT, 32'h1);
    for (int i = 0; i <= D; i++)
      rx(8'h40 + 8'(i));
    rd(LS, d);
    chk("overrun fifo", 32'h3, d & 32'h3);
    for (int i = 0; i < D; i++) begin
      rd(al(4'(i)), d);
      chk("fifo head", 32'h40 + 32'(i), d);
    end
    rd(LS, d);
    chk("fifo drained", 32'h0, d & 32'h1);
    stall <= 1'b1;
    n0 = peer_u.got_cnt;
    wr(IS, 32'hf);
    for (int i = 0; i < D + 2; i++)
      wr(al(4'(i)), 32'h50 + 32'(i));
    rd(LS, d);
    chk("tx queue full", 32'h0, d & 32'h20);
    rd(IS, d);
    chk("tx drop event", 32'h8, d & 32'h8);
    stall <= 1'b0;
    wait_tx(n0 + D + 1);
    for (int i = 0; i <= D; i++)
      chk("tx fifo", 32'h50 + 32'(i), {23'h0, peer_u.log_mem[n0 + i]});
    repeat (20) @(posedge clock);
    chk("no extra tx", 32'(n0 + D + 1), 32'(peer_u.got_cnt));
    wr(IS, 32'hf);
    wr(IM, 32'h1);
    irq_is(1'b0);
    rx(8'h77);
    irq_is(1'b1);
    wr(IM, 32'h0);
    irq_is(1'b0);
    rd(IS, d);
    chk("int status", 32'h1, d & 32'h1);
    wr(IS, 32'h1);
    rd(IS, d);
    chk("int cleared", 32'h0, d & 32'h1);
    wr(IM, 32'h1);
    irq_is(1'b0);
    rd(al(4'h5), d);
    chk("alias fifo read", 32'h77, d);
    wr(32'h5000_1200, 32'hffff_ffff);
    rd(32'h5000_1200, d);
    chk("unmapped", 32'h0, d);
    rd(al(4'hf) + 32'h4, d);
    chk("past bank", 32'h0, d);
    // infrared strobe must be ignored while in serial mode
    wr(CT, 32'h0);
    ir <= 1'b1;
    rx(8'h99);
    rd(LS, d);
    chk("ir ignored", 32'h0, d & 32'h1);
    ir <= 1'b0;
    // a write while the clock enable is low leaves the mask alone
    ce <= 1'b0;
    wr(IM, 32'h0);
    ce <= 1'b1;
    rd(IM, d);
    chk("frozen mask", 32'h1, d);
    complete_run();
  end
endmodule : tb_top
